/* src/dmc_defs.vh */
/*
 * Constants of the DAC mode control register bank: register indices,
 * field positions, reset values and the silence detect count.
 * Assumes it is included by its bare name from the design file.
 */
`ifndef DMC_DEFS_VH
`define DMC_DEFS_VH

// control word layout
`define DMC_CW_DIR_BIT 15
`define DMC_CW_IDX_HI 14
`define DMC_CW_IDX_LO 8

// register indices
`define DMC_IDX_CLK_FMT 7'h09
`define DMC_IDX_DEEMPH 7'h0a
`define DMC_IDX_READBACK 7'h0b
`define DMC_IDX_USER_OSR 7'h0c

// reset values
`define DMC_RST_CLK_FMT 8'h00
`define DMC_RST_DEEMPH 8'h00
`define DMC_RST_READBACK 8'h01
`define DMC_RST_USER_OSR 8'h00

// clock_and_format_control fields
`define DMC_FILTER_SLOW_BIT 5
`define DMC_CLK_HALVING_BIT 4
`define DMC_CLK_OUT_EN_N_BIT 3
`define DMC_LAYOUT_HI 2
`define DMC_LAYOUT_LO 0

// deemphasis_and_phase_control fields
`define DMC_PHASE_INV_BIT 5
`define DMC_DEEMPH_RATE_HI 4
`define DMC_DEEMPH_RATE_LO 3
`define DMC_DEEMPH_C_BIT 2
`define DMC_DEEMPH_B_BIT 1
`define DMC_DEEMPH_A_BIT 0

// readback_control fields
`define DMC_AUTO_STEP_BIT 7
`define DMC_WORD_INDEX_HI 6
`define DMC_WORD_INDEX_LO 0

// user_pins_and_oversampling fields
`define DMC_OSR_BIT 7
`define DMC_USER_EN_BIT 6
`define DMC_USER_LEVEL_HI 5
`define DMC_USER_LEVEL_LO 0

// serial audio layout codes
`define DMC_LAYOUT_RJ24 3'h0
`define DMC_LAYOUT_RJ20 3'h1
`define DMC_LAYOUT_RJ18 3'h2
`define DMC_LAYOUT_RJ16 3'h3
`define DMC_LAYOUT_I2S 3'h4
`define DMC_LAYOUT_LJ 3'h5

// word lengths in bits
`define DMC_WLEN_24 5'h18
`define DMC_WLEN_20 5'h14
`define DMC_WLEN_18 5'h12
`define DMC_WLEN_16 5'h10

// oversampling ratios
`define DMC_OSR_32 8'h20
`define DMC_OSR_64 8'h40
`define DMC_OSR_128 8'h80

// silence detect: consecutive zero sample periods
`define DMC_SILENCE_PERIODS 11'h400

`endif

/* src/dmc_mode_control.v */
/*
 * Mode control register bank of a six-channel audio DAC: four control
 * registers, their decoded mode outputs, the system clock output, the
 * six user/silence pins, silence detection and the readback sequencer.
 * Assumes the serial control port deserialiser runs on clk_sys and
 * hands over whole 16-bit control words; the master clock arrives on
 * a pin and must be below a quarter of clk_sys to be followed cleanly.
 */
// Notes on behaviour
// - system clock output driven while enable_n field is 0, released when 1.
// - enabled system clock output runs at full or half master rate.
// - halving field 0 gives master frequency, 1 gives half of it.
// - layout 000..011 decode to right-justified 24, 20, 18, 16 bits.
// - layout 100 selects I2S framing, 101 selects left-justified framing.
// - de-emphasis rate 00, 01, 10 select 44.1, 48, 32 kHz.
// - channels 1 and 2 de-emphasised only when pair A enable is 1.
// - channels 3 and 4 de-emphasised only when pair B enable is 1.
// - channels 5 and 6 de-emphasised only when pair C enable is 1.
// - phase invert field 1 inverts all six outputs, 0 leaves them normal.
// - phase inversion disables silence mute and silence flags.
// - silence declared after 1024 consecutive zero sample periods on a channel.
// - control word top bit 0 is a write, 1 is a read.
// - auto-step field 1 gives auto-incrementing readback, 0 single readback.
// - single read returns register at word index, which resets to 01.
// - auto-incrementing read ends at the register named by word index.
// - user pin enable 1 drives pins from the user level bits.
// - user pin enable 0 drives pins from the per-channel silence flags.
// - oversampling field 0 gives 64x up to 96 kHz, 32x above.
// - oversampling field 1 gives 128x up to 96 kHz, 64x above.
`timescale 1ns/1ps
`default_nettype none
`include "dmc_defs.vh"

module dmc_mode_control #(
	parameter CHANNELS = 6,
	parameter [10:0] SILENCE_PERIODS = `DMC_SILENCE_PERIODS
) (
	// clock, reset, enable
	input wire clk_sys,
	input wire nrst,
	input wire clkEn,
	// control word port
	input wire wordValid,
	input wire [15:0] wordIn,
	input wire readNext,
	output reg [15:0] readData,
	output reg readValid,
	output reg readLast,
	// master clock pin and system clock output pin
	input wire masterClockInput,
	output reg systemClockOutputPin,
	output reg systemClockOutputPinEn,
	// audio side status
	input wire sampleStrobe,
	input wire [CHANNELS-1:0] chanDataZero,
	input wire highRate,
	input wire silenceAutoMuteEnable,
	// decoded modes
	output reg [4:0] wordLength,
	output reg i2sMode,
	output reg leftJustMode,
	output reg filterSlow,
	output reg [1:0] deemphRateSelect,
	output reg [CHANNELS-1:0] deemphChanEnable,
	output reg outputPhaseInvert,
	output reg [7:0] overSampleRatio,
	// zero-detect results and user pins
	output reg [CHANNELS-1:0] silenceAutoMute,
	output reg [CHANNELS-1:0] userPin
);

	reg [7:0] clkFmt_q;
	reg [7:0] deemph_q;
	reg [7:0] readback_q;
	reg [7:0] userOsr_q;
	reg [6:0] readPtr_q;
	reg autoRun_q;
	reg mclkMeta_q;
	reg mclkSync_q;
	reg mclkPrev_q;
	reg halfClk_q;
	wire [CHANNELS-1:0] silenceFlag;

	wire isRead = wordIn[`DMC_CW_DIR_BIT];
	wire [6:0] wordIdx = wordIn[`DMC_CW_IDX_HI:`DMC_CW_IDX_LO];
	wire [7:0] wordData = wordIn[7:0];
	wire autoStep = readback_q[`DMC_AUTO_STEP_BIT];
	wire [6:0] wordIndex = readback_q[`DMC_WORD_INDEX_HI:`DMC_WORD_INDEX_LO];
	wire phaseInv = deemph_q[`DMC_PHASE_INV_BIT];

	// register contents by index; other indices belong to other blocks
	function [7:0] regRead;
		input [6:0] idx;
		begin
			case (idx)
				`DMC_IDX_CLK_FMT: regRead = clkFmt_q & 8'h3f;
				`DMC_IDX_DEEMPH: regRead = deemph_q & 8'h3f;
				`DMC_IDX_READBACK: regRead = readback_q;
				`DMC_IDX_USER_OSR: regRead = userOsr_q;
				default: regRead = 8'h00;
			endcase
		end
	endfunction

	// one write strobe per register; indices outside 9..12 belong to other blocks
	reg wrClkFmt;
	reg wrDeemph;
	reg wrReadback;
	reg wrUserOsr;

	always @* begin
		wrClkFmt = 1'b0;
		wrDeemph = 1'b0;
		wrReadback = 1'b0;
		wrUserOsr = 1'b0;
		if (clkEn && wordValid && !isRead) begin
			case (wordIdx)
				`DMC_IDX_CLK_FMT: wrClkFmt = 1'b1;
				`DMC_IDX_DEEMPH: wrDeemph = 1'b1;
				`DMC_IDX_READBACK: wrReadback = 1'b1;
				`DMC_IDX_USER_OSR: wrUserOsr = 1'b1;
				default: wrClkFmt = 1'b0;
			endcase
		end
	end

	// register writes
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			clkFmt_q <= `DMC_RST_CLK_FMT;
			deemph_q <= `DMC_RST_DEEMPH;
			readback_q <= `DMC_RST_READBACK;
			userOsr_q <= `DMC_RST_USER_OSR;
		end else begin
			if (wrClkFmt)
				clkFmt_q <= wordData;
			if (wrDeemph)
				deemph_q <= wordData;
			if (wrReadback)
				readback_q <= wordData;
			if (wrUserOsr)
				userOsr_q <= wordData;
		end
	end

	// readback: single returns word index, auto steps from the requested index up to it
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			readPtr_q <= 7'h00;
			autoRun_q <= 1'b0;
			readData <= 16'h0000;
			readValid <= 1'b0;
			readLast <= 1'b0;
		end else if (clkEn) begin
			readValid <= 1'b0;
			if (wordValid && isRead) begin
				readValid <= 1'b1;
				if (autoStep && wordIdx != wordIndex) begin
					readData <= {1'b1, wordIdx, regRead(wordIdx)};
					readPtr_q <= wordIdx + 7'h01;
					autoRun_q <= 1'b1;
					readLast <= 1'b0;
				end else if (autoStep) begin
					readData <= {1'b1, wordIdx, regRead(wordIdx)};
					autoRun_q <= 1'b0;
					readLast <= 1'b1;
				end else begin
					readData <= {1'b1, wordIndex, regRead(wordIndex)};
					autoRun_q <= 1'b0;
					readLast <= 1'b1;
				end
			end else if (readNext && autoRun_q && !wordValid) begin
				readValid <= 1'b1;
				readData <= {1'b1, readPtr_q, regRead(readPtr_q)};
				readPtr_q <= readPtr_q + 7'h01;
				if (readPtr_q == wordIndex) begin
					autoRun_q <= 1'b0;
					readLast <= 1'b1;
				end
			end else if (wordValid) begin
				autoRun_q <= 1'b0;
			end
		end
	end

	// master clock sampled through two flops before use
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mclkMeta_q <= 1'b0;
			mclkSync_q <= 1'b0;
			mclkPrev_q <= 1'b0;
			halfClk_q <= 1'b0;
		end else if (clkEn) begin
			mclkMeta_q <= masterClockInput;
			mclkSync_q <= mclkMeta_q;
			mclkPrev_q <= mclkSync_q;
			if (mclkSync_q && !mclkPrev_q)
				halfClk_q <= ~halfClk_q;
		end
	end

	// system clock output; held low and released while disabled
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			systemClockOutputPin <= 1'b0;
			systemClockOutputPinEn <= 1'b0;
		end else if (clkEn) begin
			systemClockOutputPinEn <= ~clkFmt_q[`DMC_CLK_OUT_EN_N_BIT];
			if (clkFmt_q[`DMC_CLK_OUT_EN_N_BIT])
				systemClockOutputPin <= 1'b0;
			else if (clkFmt_q[`DMC_CLK_HALVING_BIT])
				systemClockOutputPin <= halfClk_q;
			else
				systemClockOutputPin <= mclkPrev_q;
		end
	end

	// one silence counter per channel; each sees only its own zero status
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : gSilence
			dmc_silence_counter #(
				.PERIODS(SILENCE_PERIODS)
			) u_silence (
				.clk_sys(clk_sys),
				.nrst(nrst),
				.clkEn(clkEn),
				.sampleStrobe(sampleStrobe),
				.dataZero(chanDataZero[ch]),
				.silent_q(silenceFlag[ch])
			);
		end
	endgenerate

	// silence results and user pins
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			silenceAutoMute <= {CHANNELS{1'b0}};
			userPin <= {CHANNELS{1'b0}};
		end else if (clkEn) begin
			// inversion hides silence entirely, since the zero code no longer means silence
			silenceAutoMute <= (phaseInv || !silenceAutoMuteEnable) ? {CHANNELS{1'b0}} : silenceFlag;
			if (userOsr_q[`DMC_USER_EN_BIT])
				userPin <= userOsr_q[`DMC_USER_LEVEL_HI:`DMC_USER_LEVEL_LO];
			else
				userPin <= phaseInv ? {CHANNELS{1'b0}} : silenceFlag;
		end
	end

	// decoded mode outputs
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wordLength <= `DMC_WLEN_24;
			i2sMode <= 1'b0;
			leftJustMode <= 1'b0;
			filterSlow <= 1'b0;
			deemphRateSelect <= 2'h0;
			deemphChanEnable <= {CHANNELS{1'b0}};
			outputPhaseInvert <= 1'b0;
			overSampleRatio <= `DMC_OSR_64;
		end else if (clkEn) begin
			filterSlow <= clkFmt_q[`DMC_FILTER_SLOW_BIT];
			i2sMode <= 1'b0;
			leftJustMode <= 1'b0;
			case (clkFmt_q[`DMC_LAYOUT_HI:`DMC_LAYOUT_LO])
				`DMC_LAYOUT_RJ24: wordLength <= `DMC_WLEN_24;
				`DMC_LAYOUT_RJ20: wordLength <= `DMC_WLEN_20;
				`DMC_LAYOUT_RJ18: wordLength <= `DMC_WLEN_18;
				`DMC_LAYOUT_RJ16: wordLength <= `DMC_WLEN_16;
				`DMC_LAYOUT_I2S: begin
					wordLength <= `DMC_WLEN_24;
					i2sMode <= 1'b1;
				end
				`DMC_LAYOUT_LJ: begin
					wordLength <= `DMC_WLEN_24;
					leftJustMode <= 1'b1;
				end
				// reserved codes fall back to the reset layout
				default: wordLength <= `DMC_WLEN_24;
			endcase
			deemphRateSelect <= deemph_q[`DMC_DEEMPH_RATE_HI:`DMC_DEEMPH_RATE_LO];
			deemphChanEnable <= {{2{deemph_q[`DMC_DEEMPH_C_BIT]}},
				{2{deemph_q[`DMC_DEEMPH_B_BIT]}},
				{2{deemph_q[`DMC_DEEMPH_A_BIT]}}};
			outputPhaseInvert <= phaseInv;
			if (userOsr_q[`DMC_OSR_BIT])
				overSampleRatio <= highRate ? `DMC_OSR_64 : `DMC_OSR_128;
			else
				overSampleRatio <= highRate ? `DMC_OSR_32 : `DMC_OSR_64;
		end
	end

endmodule // dmc_mode_control

// one channel's run of zero samples; the flag follows the run, not the data word
module dmc_silence_counter #(
	parameter [10:0] PERIODS = `DMC_SILENCE_PERIODS
) (
	// clock, reset, enable
	input wire clk_sys,
	input wire nrst,
	input wire clkEn,
	// one channel's sample status
	input wire sampleStrobe,
	input wire dataZero,
	// silence flag
	output reg silent_q
);

	reg [10:0] zeroRun_q;
	reg [10:0] zeroRun_d;
	reg silent_d;
	wire runFull = (zeroRun_q == PERIODS);
	wire runLast = (zeroRun_q == PERIODS - 11'h001);

	// the run saturates at the limit, so a long silence never wraps back to loud
	always @* begin
		zeroRun_d = zeroRun_q;
		silent_d = silent_q;
		if (sampleStrobe) begin
			if (!dataZero) begin
				// any loud sample restarts the count and drops the flag at once
				zeroRun_d = 11'h000;
				silent_d = 1'b0;
			end else if (!runFull) begin
				zeroRun_d = zeroRun_q + 11'h001;
				if (runLast)
					silent_d = 1'b1;
			end
		end
	end

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			zeroRun_q <= 11'h000;
			silent_q <= 1'b0;
		end else if (clkEn) begin
			zeroRun_q <= zeroRun_d;
			silent_q <= silent_d;
		end
	end

endmodule // dmc_silence_counter

`default_nettype wire

/* testbench/dmc_mode_control_assertions.sv */
/* checker for the dmc_mode_control ports.
   assumes it is bound to every dmc_mode_control instance. */
`timescale 1ns/1ps
`default_nettype none
module dmc_mode_control_chk #(
	parameter CHANNELS = 6
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// control port
	input wire logic clkEn,
	input wire logic wordValid,
	input wire logic [15:0] wordIn,
	input wire logic readValid,
	// audio side and modes
	input wire logic highRate,
	input wire logic sampleStrobe,
	input wire logic [CHANNELS-1:0] chanDataZero,
	input wire logic [7:0] overSampleRatio,
	input wire logic outputPhaseInvert,
	input wire logic [CHANNELS-1:0] deemphChanEnable,
	input wire logic [CHANNELS-1:0] silenceAutoMute,
	input wire logic systemClockOutputPin,
	input wire logic systemClockOutputPinEn
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence s_taken;
		clkEn && wordValid;
	endsequence
	sequence s_pairWrite;
		s_taken ##0 wordIn[15:8] == 8'h0a;
	endsequence
	sequence s_loudSample;
		clkEn && sampleStrobe && !chanDataZero[0];
	endsequence
	property p_readAnswer;
		s_taken ##0 wordIn[15] |=> readValid;
	endproperty
	property p_writeQuiet;
		s_taken ##0 !wordIn[15] |=> !readValid;
	endproperty
	property p_clkOff;
		!systemClockOutputPinEn |-> !systemClockOutputPin;
	endproperty
	property p_osr128;
		overSampleRatio == 8'h80 |-> !$past(highRate);
	endproperty
	property p_osr32;
		overSampleRatio == 8'h20 |-> $past(highRate);
	endproperty
	property p_invertQuiet;
		outputPhaseInvert |-> silenceAutoMute == '0;
	endproperty
	// pair enables show the written bits two edges after the write is taken
	property p_pairs;
		s_pairWrite |-> ##2 deemphChanEnable == {{2{$past(wordIn[2], 2)}}, {2{$past(wordIn[1], 2)}},
			{2{$past(wordIn[0], 2)}}};
	endproperty
	// flag drops on the loud sample, the mute one cycle after
	property p_silenceClear;
		s_loudSample |-> ##2 !silenceAutoMute[0];
	endproperty
	a_readAnswer: assert property (p_readAnswer) else $error("read not answered");
	a_writeQuiet: assert property (p_writeQuiet) else $error("write answered");
	a_clkOff: assert property (p_clkOff) else $error("clock out active while off");
	a_osr128: assert property (p_osr128) else $error("128x at high rate");
	a_osr32: assert property (p_osr32) else $error("32x at low rate");
	a_invertQuiet: assert property (p_invertQuiet) else $error("mute while inverted");
	a_pairs: assert property (p_pairs) else $error("pair enables split");
	a_silenceClear: assert property (p_silenceClear) else $error("mute kept");
endmodule // dmc_mode_control_chk
bind dmc_mode_control dmc_mode_control_chk #(.CHANNELS(CHANNELS)) u_chk (.clk_sys(clk_sys), .nrst(nrst),
	.clkEn(clkEn), .wordValid(wordValid), .wordIn(wordIn), .readValid(readValid), .highRate(highRate),
	.sampleStrobe(sampleStrobe), .chanDataZero(chanDataZero), .overSampleRatio(overSampleRatio),
	.outputPhaseInvert(outputPhaseInvert), .deemphChanEnable(deemphChanEnable),
	.silenceAutoMute(silenceAutoMute), .systemClockOutputPin(systemClockOutputPin),
	.systemClockOutputPinEn(systemClockOutputPinEn));
`default_nettype wire

/* testbench/dmc_host_model.sv */
/* host controller model on the control word port.
   assumes the bench calls wr and rd after reset is released. */
`timescale 1ns/1ps
`default_nettype none
module dmc_host_model (
	// clock
	input wire logic clk_sys,
	// control word port
	output logic wordValid,
	output logic [15:0] wordIn,
	output logic readNext,
	input wire logic [15:0] readData,
	input wire logic readValid,
	input wire logic readLast
);
	initial begin
		wordValid = 1'b0;
		wordIn = 16'h0000;
		readNext = 1'b0;
	end
	// callers never pass reserved layout or rate codes
	task wr(input logic [6:0] idx, input logic [7:0] d);
		begin
			@(posedge clk_sys);
			wordValid <= 1'b1;
			wordIn <= {1'b0, idx, d};
			@(posedge clk_sys);
			wordValid <= 1'b0;
			wordIn <= ~{1'b0, idx, d};
		end
	endtask
	task rd(input logic step, input logic [6:0] idx, output logic [15:0] d, output logic l, output logic ok);
		integer i;
		begin
			@(posedge clk_sys);
			if (step) begin
				readNext <= 1'b1;
			end else begin
				wordValid <= 1'b1;
				wordIn <= {1'b1, idx, 8'h00};
			end
			@(posedge clk_sys);
			wordValid <= 1'b0;
			readNext <= 1'b0;
			wordIn <= ~{1'b1, idx, 8'h00};
			ok = 1'b0;
			d = 16'h0000;
			l = 1'b0;
			for (i = 0; i < 4 && !ok; i = i + 1) begin
				#1;
				if (readValid === 1'b1) begin
					ok = 1'b1;
					d = readData;
					l = readLast;
				end else begin
					@(posedge clk_sys);
				end
			end
		end
	endtask
endmodule // dmc_host_model
`default_nettype wire

/* testbench/tb.sv */
/* self-checking bench for dmc_mode_control.
   assumes the host model and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; $display("mismatch t=%0t got %h", $time, g); end end
module tb;
	logic clk_sys = 1'b0, nrst = 1'b0, sampleStrobe = 1'b0, highRate = 1'b0, silenceAutoMuteEnable = 1'b0;
	logic [5:0] chanDataZero = 6'h00;
	logic clkEn = 1'b1, filterSlow;
	logic [2:0] mcDiv = 3'h0;
	logic wordValid, readNext, readValid, readLast, pin, pinEn, i2sMode, leftJustMode, outputPhaseInvert;
	logic [15:0] wordIn, readData, d;
	logic [4:0] wordLength;
	logic [1:0] deemphRateSelect;
	logic [5:0] deemphChanEnable, silenceAutoMute, userPin;
	logic [7:0] overSampleRatio;
	logic l, ok;
	integer errors = 0, checks = 0, i, n;
	logic [4:0] wl [0:5] = '{5'h18, 5'h14, 5'h12, 5'h10, 5'h18, 5'h18};
	logic [15:0] aut [0:3] = '{16'h8900, 16'h8a00, 16'h8b8c, 16'h8c00};
	always #5 clk_sys = ~clk_sys;
	// master clock at an eighth of clk_sys, inside the synchroniser limit
	always @(posedge clk_sys) mcDiv <= mcDiv + 3'h1;
	dmc_mode_control #(.SILENCE_PERIODS(11'h004)) dut (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn),
		.wordValid(wordValid), .wordIn(wordIn), .readNext(readNext), .readData(readData),
		.readValid(readValid), .readLast(readLast), .masterClockInput(mcDiv[2]), .systemClockOutputPin(pin),
		.systemClockOutputPinEn(pinEn), .sampleStrobe(sampleStrobe), .chanDataZero(chanDataZero),
		.highRate(highRate), .silenceAutoMuteEnable(silenceAutoMuteEnable), .wordLength(wordLength),
		.i2sMode(i2sMode), .leftJustMode(leftJustMode), .filterSlow(filterSlow), .deemphRateSelect(deemphRateSelect),
		.deemphChanEnable(deemphChanEnable), .outputPhaseInvert(outputPhaseInvert),
		.overSampleRatio(overSampleRatio), .silenceAutoMute(silenceAutoMute), .userPin(userPin));
	dmc_host_model u_host (.clk_sys(clk_sys), .wordValid(wordValid), .wordIn(wordIn), .readNext(readNext),
		.readData(readData), .readValid(readValid), .readLast(readLast));
	task wt;
		begin
			repeat (2) @(posedge clk_sys);
			#1;
		end
	endtask
	task strobe(input logic [5:0] z);
		begin
			@(posedge clk_sys);
			sampleStrobe <= 1'b1;
			chanDataZero <= z;
			@(posedge clk_sys);
			sampleStrobe <= 1'b0;
		end
	endtask
	task rises(input logic [7:0] w);
		integer k;
		logic p;
		begin
			u_host.wr(7'h09, w);
			wt;
			n = 0;
			p = pin;
			for (k = 0; k < 64; k++) begin
				@(posedge clk_sys);
				#1;
				if (pin && !p) n++;
				p = pin;
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d errors %0d", checks, errors);
			if (errors == 0 && checks > 0) $display("TEST PASSED");
			else $display("TEST FAILED");
			$finish;
		end
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		nrst <= 1'b1;
		wt;
		`CHK({wordLength, overSampleRatio, pinEn}, {5'h18, 8'h40, 1'b1})
		`CHK({deemphRateSelect, deemphChanEnable, outputPhaseInvert}, 9'h000)
		u_host.rd(1'b0, 7'h00, d, l, ok);
		`CHK({ok, l, d}, 18'h38100)
		$display("defaults done");
		u_host.wr(7'h0b, 8'h8c);
		for (i = 0; i < 4; i++) begin
			u_host.rd(i != 0, 7'h09, d, l, ok);
			`CHK({ok, l, d}, {1'b1, i == 3, aut[i]})
		end
		u_host.wr(7'h0b, 8'h09);
		for (i = 0; i < 6; i++) begin
			u_host.wr(7'h09, {2'b00, i == 5, i[4:0]});
			wt;
			`CHK({wordLength, i2sMode, leftJustMode, filterSlow}, {wl[i], i == 4, i == 5, i == 5})
		end
		u_host.rd(1'b0, 7'h00, d, l, ok);
		`CHK(d, 16'h8925)
		$display("readback and layout done");
		u_host.wr(7'h0a, 8'h37);
		wt;
		`CHK({outputPhaseInvert, deemphRateSelect, deemphChanEnable}, 9'h1bf)
		u_host.wr(7'h0a, 8'h0a);
		wt;
		`CHK({outputPhaseInvert, deemphRateSelect, deemphChanEnable}, 9'h04c)
		u_host.wr(7'h0a, 8'h01);
		wt;
		`CHK({outputPhaseInvert, deemphRateSelect, deemphChanEnable}, 9'h003)
		rises(8'h00);
		`CHK(n, 8)
		rises(8'h10);
		`CHK(n, 4)
		rises(8'h08);
		`CHK({pinEn, n[3:0]}, 5'h00)
		$display("modes and clock out done");
		u_host.wr(7'h0c, 8'hea);
		wt;
		`CHK({userPin, overSampleRatio}, 14'h2a80)
		@(posedge clk_sys) highRate <= 1'b1;
		wt;
		`CHK(overSampleRatio, 8'h40)
		u_host.wr(7'h0c, 8'h00);
		wt;
		`CHK(overSampleRatio, 8'h20)
		@(posedge clk_sys) silenceAutoMuteEnable <= 1'b1;
		repeat (3) strobe(6'h05);
		wt;
		`CHK(userPin, 6'h00)
		strobe(6'h05);
		wt;
		`CHK({userPin, silenceAutoMute}, 12'h145)
		u_host.wr(7'h0a, 8'h20);
		wt;
		`CHK({userPin, silenceAutoMute}, 12'h000)
		u_host.wr(7'h0a, 8'h00);
		strobe(6'h00);
		wt;
		`CHK({userPin, silenceAutoMute}, 12'h000)
		@(posedge clk_sys) clkEn <= 1'b0;
		u_host.wr(7'h0c, 8'h7f);
		@(posedge clk_sys) clkEn <= 1'b1;
		wt;
		`CHK(userPin, 6'h00)
		$display("pins and silence done");
		tally_and_finish;
	end
endmodule // tb
`default_nettype wire
